// >>> core/partial_resize_area_calc.sv
// partial-resize set area calculator with APB register access
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "resize_params.svh"
module partial_resize_area_calc #(
    parameter int DIM_W = 16
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             calc_done
);
    localparam int FB = `RSZ_FRAC_BITS;

    // phase product: quotient times step plus fraction
    function automatic logic [47:0] phase_at(input logic [31:0] q,
                                             input logic [31:0] step,
                                             input logic [11:0] fr);
        phase_at = 48'(q) * 48'(step) + 48'(fr);
    endfunction

    function automatic logic [47:0] unity_of(input logic [DIM_W:0] n);
        unity_of = 48'(n) << FB;
    endfunction

    div_if div_bus ();

    seq_divider u_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .div_bus (div_bus)
    );

    // configuration and apb state
    resize_pkg::word_t          src_size_reg, src_size_next;
    resize_pkg::word_t          dst_size_reg, dst_size_next;
    resize_pkg::word_t          upd_lt_reg, upd_lt_next;
    resize_pkg::word_t          upd_rb_reg, upd_rb_next;
    resize_pkg::word_t          frac_reg, frac_next;
    logic [31:0]                prdata_reg, prdata_next;
    logic                       pready_reg, pready_next;
    logic                       pslverr_reg, pslverr_next;

    // calculation state
    resize_pkg::calc_state_e    state_reg, state_next;
    logic                       axis_reg, axis_next;
    logic                       issued_reg, issued_next;
    logic                       done_reg, done_next;
    logic [31:0]                step_reg, step_next;
    logic [31:0]                qa_reg, qa_next;
    logic [31:0]                qb_reg, qb_next;
    logic [DIM_W-1:0]           dofs_reg [2];
    logic [DIM_W-1:0]           dofs_next [2];
    logic [DIM_W-1:0]           sofs_reg [2];
    logic [DIM_W-1:0]           sofs_next [2];
    logic [DIM_W-1:0]           dw_reg [2];
    logic [DIM_W-1:0]           dw_next [2];
    logic [DIM_W-1:0]           sw_reg [2];
    logic [DIM_W-1:0]           sw_next [2];
    logic [21:0]                ph_reg [2];
    logic [21:0]                ph_next [2];

    logic                       busy;
    logic                       access;
    logic                       commit_wr;
    logic                       addr_hit;
    logic [31:0]                rd_mux;
    logic                       start_req;

    // per-axis operands
    logic [DIM_W-1:0]           s_sz, d_sz, u_lo, u_hi;
    logic [11:0]                fr;

    // capture arithmetic
    logic                       has_lo, at_edge, lo_ok, hi_ok;
    logic [31:0]                dofs_c, sofs_c, dw_c, sw_c;
    logic [47:0]                ph_c, hi_ph;

    assign busy = (state_reg != resize_pkg::CALC_IDLE);

    always_comb begin
        s_sz = axis_reg ? src_size_reg[`RSZ_HI_FIELD] : src_size_reg[`RSZ_LO_FIELD];
        d_sz = axis_reg ? dst_size_reg[`RSZ_HI_FIELD] : dst_size_reg[`RSZ_LO_FIELD];
        u_lo = axis_reg ? upd_lt_reg[`RSZ_HI_FIELD] : upd_lt_reg[`RSZ_LO_FIELD];
        u_hi = axis_reg ? upd_rb_reg[`RSZ_HI_FIELD] : upd_rb_reg[`RSZ_LO_FIELD];
        // the full-resize fraction is reused as is, range is software's job
        fr   = axis_reg ? frac_reg[`RSZ_FRAC_V_FIELD] : frac_reg[`RSZ_FRAC_H_FIELD];
    end

    // offsets and sizes of one axis from the three quotients
    always_comb begin
        has_lo  = (u_lo > DIM_W'(1));
        lo_ok   = phase_at(qa_reg, step_reg, fr) >= unity_of({1'b0, u_lo} - 1'b1);
        if (!has_lo) begin
            dofs_c = '0;
        end else begin
            dofs_c = lo_ok ? qa_reg : qa_reg + 32'h0000_0001;
        end
        ph_c    = phase_at(dofs_c, step_reg, fr);
        sofs_c  = has_lo ? ph_c[43:12] : 32'h0000_0000;
        at_edge = !(({1'b0, u_hi} + 1'b1 + 1'b1) < {1'b0, s_sz});
        hi_ok   = phase_at(qb_reg, step_reg, fr) >= unity_of({1'b0, u_hi} + 1'b1);
        // one less step backs the last pixel off when the test passes
        hi_ph   = phase_at(hi_ok ? qb_reg - 32'h0000_0001 : qb_reg,
                           step_reg, fr);
        if (at_edge) begin
            dw_c = 32'(d_sz) - dofs_c;
            sw_c = 32'(s_sz) - sofs_c;
        end else begin
            dw_c = qb_reg - dofs_c + (hi_ok ? 32'h0000_0000 : 32'h0000_0001);
            sw_c = hi_ph[43:12] - sofs_c + 32'h0000_0002;
        end
    end

    // sequencer: step, left quotient, right quotient, capture, per axis
    always_comb begin
        state_next       = state_reg;
        axis_next        = axis_reg;
        issued_next      = issued_reg;
        done_next        = done_reg;
        step_next        = step_reg;
        qa_next          = qa_reg;
        qb_next          = qb_reg;
        dofs_next        = dofs_reg;
        sofs_next        = sofs_reg;
        dw_next          = dw_reg;
        sw_next          = sw_reg;
        ph_next          = ph_reg;
        div_bus.start    = 1'b0;
        div_bus.dividend = 32'h0000_0000;
        div_bus.divisor  = 32'(s_sz);
        case (state_reg)
            resize_pkg::CALC_IDLE: begin
                if (start_req) begin
                    state_next  = resize_pkg::CALC_STEP;
                    axis_next   = 1'b0;
                    issued_next = 1'b0;
                    done_next   = 1'b0;
                end
            end
            resize_pkg::CALC_STEP: begin
                div_bus.dividend = 32'(s_sz) << FB;
                div_bus.divisor  = 32'(d_sz);
                div_bus.start    = !issued_reg;
                issued_next      = 1'b1;
                if (div_bus.done) begin
                    step_next   = div_bus.quotient;
                    issued_next = 1'b0;
                    state_next  = resize_pkg::CALC_LEFT;
                end
            end
            resize_pkg::CALC_LEFT: begin
                div_bus.dividend = 32'(d_sz) * 32'(u_lo - DIM_W'(1));
                div_bus.start    = !issued_reg;
                issued_next      = 1'b1;
                if (div_bus.done) begin
                    qa_next     = div_bus.quotient;
                    issued_next = 1'b0;
                    state_next  = resize_pkg::CALC_RIGHT;
                end
            end
            resize_pkg::CALC_RIGHT: begin
                div_bus.dividend = 32'(d_sz) * (32'(u_hi) + 32'h0000_0001);
                div_bus.start    = !issued_reg;
                issued_next      = 1'b1;
                if (div_bus.done) begin
                    qb_next     = div_bus.quotient;
                    issued_next = 1'b0;
                    state_next  = resize_pkg::CALC_CAPT;
                end
            end
            resize_pkg::CALC_CAPT: begin
                dofs_next[axis_reg] = dofs_c[DIM_W-1:0];
                sofs_next[axis_reg] = sofs_c[DIM_W-1:0];
                dw_next[axis_reg]   = dw_c[DIM_W-1:0];
                sw_next[axis_reg]   = sw_c[DIM_W-1:0];
                // vertical integer part is one bit narrower
                ph_next[axis_reg] = axis_reg ? {1'b0, ph_c[20:0]} : ph_c[21:0];
                if (axis_reg) begin
                    state_next = resize_pkg::CALC_IDLE;
                    done_next  = 1'b1;
                end else begin
                    axis_next  = 1'b1;
                    state_next = resize_pkg::CALC_STEP;
                end
            end
            default: begin
                state_next = resize_pkg::CALC_IDLE;
            end
        endcase
    end

    // apb: one wait state, every access answered in the second access cycle
    always_comb begin
        access    = psel && penable && !pready_reg;
        commit_wr = psel && penable && pready_reg && pwrite;
        start_req = commit_wr && (paddr == `RSZ_OFS_CTRL) && pwdata[`RSZ_CTRL_START_BIT]
                    && !busy;
        addr_hit  = 1'b1;
        rd_mux    = 32'h0000_0000;
        case (paddr)
            `RSZ_OFS_CTRL:       rd_mux = 32'h0000_0000;
            `RSZ_OFS_STATUS:     rd_mux = {30'h0, done_reg, busy};
            `RSZ_OFS_SRC_SIZE:   rd_mux = src_size_reg;
            `RSZ_OFS_DST_SIZE:   rd_mux = dst_size_reg;
            `RSZ_OFS_UPD_LT:     rd_mux = upd_lt_reg;
            `RSZ_OFS_UPD_RB:     rd_mux = upd_rb_reg;
            `RSZ_OFS_PHASE_FRAC: rd_mux = frac_reg;
            `RSZ_OFS_RES_DST_LT: rd_mux = {16'(dofs_reg[1]), 16'(dofs_reg[0])};
            `RSZ_OFS_RES_DST_WH: rd_mux = {16'(dw_reg[1]), 16'(dw_reg[0])};
            `RSZ_OFS_RES_SRC_LT: rd_mux = {16'(sofs_reg[1]), 16'(sofs_reg[0])};
            `RSZ_OFS_RES_SRC_WH: rd_mux = {16'(sw_reg[1]), 16'(sw_reg[0])};
            `RSZ_OFS_RES_H_PH:   rd_mux = {10'h000, ph_reg[0]};
            `RSZ_OFS_RES_V_PH:   rd_mux = {10'h000, ph_reg[1]};
            default:             addr_hit = 1'b0;
        endcase
        pready_next   = access;
        pslverr_next  = access && !addr_hit;
        prdata_next   = (access && !pwrite) ? rd_mux : prdata_reg;
        src_size_next = src_size_reg;
        dst_size_next = dst_size_reg;
        upd_lt_next   = upd_lt_reg;
        upd_rb_next   = upd_rb_reg;
        frac_next     = frac_reg;
        // geometry is frozen while a calculation runs so operands stay stable
        if (commit_wr && !busy) begin
            case (paddr)
                `RSZ_OFS_SRC_SIZE:   src_size_next = pwdata;
                `RSZ_OFS_DST_SIZE:   dst_size_next = pwdata;
                `RSZ_OFS_UPD_LT:     upd_lt_next   = pwdata;
                `RSZ_OFS_UPD_RB:     upd_rb_next   = pwdata;
                `RSZ_OFS_PHASE_FRAC: frac_next     = pwdata & 32'h0fff_0fff;
                default:             frac_next     = frac_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src_size_reg <= `RSZ_WORD_RESET;
            dst_size_reg <= `RSZ_WORD_RESET;
            upd_lt_reg   <= `RSZ_WORD_RESET;
            upd_rb_reg   <= `RSZ_WORD_RESET;
            frac_reg     <= `RSZ_WORD_RESET;
            prdata_reg   <= `RSZ_WORD_RESET;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
        end else begin
            src_size_reg <= src_size_next;
            dst_size_reg <= dst_size_next;
            upd_lt_reg   <= upd_lt_next;
            upd_rb_reg   <= upd_rb_next;
            frac_reg     <= frac_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg  <= resize_pkg::CALC_IDLE;
            axis_reg   <= 1'b0;
            issued_reg <= 1'b0;
            done_reg   <= 1'b0;
            step_reg   <= '0;
            qa_reg     <= '0;
            qb_reg     <= '0;
            for (int i = 0; i < 2; i++) begin
                dofs_reg[i] <= '0;
                sofs_reg[i] <= '0;
                dw_reg[i] <= '0;
                sw_reg[i] <= '0;
                ph_reg[i] <= '0;
            end
        end else begin
            state_reg  <= state_next;
            axis_reg   <= axis_next;
            issued_reg <= issued_next;
            done_reg   <= done_next;
            step_reg   <= step_next;
            qa_reg     <= qa_next;
            qb_reg     <= qb_next;
            dofs_reg   <= dofs_next;
            sofs_reg   <= sofs_next;
            dw_reg     <= dw_next;
            sw_reg     <= sw_next;
            ph_reg     <= ph_next;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign calc_done = done_reg;
endmodule

// >>> core/resize_params.svh
// offsets, field positions and fixed-point constants of the resize area calculator
// Summary of operation
// - left test compares scaled left position
// - dst left is quotient, plus one if false
// - top test compares scaled top position
// - dst top is quotient, plus one if false
// - src left is integer of left phase
// - src top is integer of top phase
// - right test unless right edge reached
// - dst width from right quotient minus left
// - bottom test unless bottom edge reached
// - dst height from bottom quotient minus top
// - src width reuses right test or edge
// - src width from rounded-back right phase
// - src height reuses bottom test or edge
// - src height subtracts one when test true
// - horizontal phase: 10 integer, 12 fraction bits
// - vertical phase: 9 integer, 12 fraction bits
`ifndef RESIZE_PARAMS_SVH
`define RESIZE_PARAMS_SVH

`define RSZ_OFS_CTRL       8'h00
`define RSZ_OFS_STATUS     8'h04
`define RSZ_OFS_SRC_SIZE   8'h08
`define RSZ_OFS_DST_SIZE   8'h0c
`define RSZ_OFS_UPD_LT     8'h10
`define RSZ_OFS_UPD_RB     8'h14
`define RSZ_OFS_PHASE_FRAC 8'h18
`define RSZ_OFS_RES_DST_LT 8'h1c
`define RSZ_OFS_RES_DST_WH 8'h20
`define RSZ_OFS_RES_SRC_LT 8'h24
`define RSZ_OFS_RES_SRC_WH 8'h28
`define RSZ_OFS_RES_H_PH   8'h2c
`define RSZ_OFS_RES_V_PH   8'h30

`define RSZ_CTRL_START_BIT 0
`define RSZ_STAT_BUSY_BIT  0
`define RSZ_STAT_DONE_BIT  1
`define RSZ_LO_FIELD       15:0
`define RSZ_HI_FIELD       31:16
`define RSZ_FRAC_H_FIELD   11:0
`define RSZ_FRAC_V_FIELD   27:16

`define RSZ_FRAC_BITS      12
`define RSZ_H_INT_BITS     10
`define RSZ_V_INT_BITS     9
`define RSZ_DIV_W          32
`define RSZ_DIV_CNT_W      6
`define RSZ_WORD_RESET     32'h0000_0000

`endif

// >>> core/resize_pkg.sv
// types shared by the resize area calculator
package resize_pkg;
    typedef enum logic [4:0] {
        CALC_IDLE  = 5'b00001,
        CALC_STEP  = 5'b00010,
        CALC_LEFT  = 5'b00100,
        CALC_RIGHT = 5'b01000,
        CALC_CAPT  = 5'b10000
    } calc_state_e;

    typedef logic [31:0] word_t;
endpackage

// >>> core/div_if.sv
// divider request and answer between the calculator and its divider
`timescale 1ns/10ps
`include "resize_params.svh"
interface div_if;
    logic                    start;
    logic [`RSZ_DIV_W-1:0]   dividend;
    logic [`RSZ_DIV_W-1:0]   divisor;
    logic [`RSZ_DIV_W-1:0]   quotient;
    logic                    done;

    modport master (output start, output dividend, output divisor,
                    input quotient, input done);
    modport slave  (input start, input dividend, input divisor,
                    output quotient, output done);
endinterface

// >>> core/seq_divider.sv
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/10ps
`include "resize_params.svh"
module seq_divider (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // request and answer
    div_if.slave      div_bus
);
    localparam int W = `RSZ_DIV_W;

    logic [W:0]                 rem_reg, rem_next;
    logic [W-1:0]               quo_reg, quo_next;
    logic [W-1:0]               dsr_reg, dsr_next;
    logic [`RSZ_DIV_CNT_W-1:0]  cnt_reg, cnt_next;
    logic                       done_reg, done_next;

    always_comb begin
        logic [W:0] shifted;
        logic [W:0] trial;
        shifted   = {rem_reg[W-1:0], quo_reg[W-1]};
        trial     = shifted - {1'b0, dsr_reg};
        rem_next  = rem_reg;
        quo_next  = quo_reg;
        dsr_next  = dsr_reg;
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (div_bus.start) begin
            rem_next = '0;
            quo_next = div_bus.dividend;
            dsr_next = div_bus.divisor;
            cnt_next = `RSZ_DIV_CNT_W'(W);
        end else if (cnt_reg != '0) begin
            // zero divisor yields all ones, never hangs
            if (!trial[W]) begin
                rem_next = trial;
                quo_next = {quo_reg[W-2:0], 1'b1};
            end else begin
                rem_next = shifted;
                quo_next = {quo_reg[W-2:0], 1'b0};
            end
            cnt_next  = cnt_reg - 1'b1;
            done_next = (cnt_reg == `RSZ_DIV_CNT_W'(1));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rem_reg  <= '0;
            quo_reg  <= '0;
            dsr_reg  <= '0;
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            rem_reg  <= rem_next;
            quo_reg  <= quo_next;
            dsr_reg  <= dsr_next;
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign div_bus.quotient = quo_reg;
    assign div_bus.done     = done_reg;
endmodule

// >>> tb/resize_monitor.sv
// port-level assertion checker for the resize area calculator
`timescale 1ns/10ps
module resize_monitor (
    // clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        calc_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic start_acc;
    assign start_acc = pready && pwrite && paddr == 8'h00 && pwdata[0];

    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // done drops at once, then the two axes take well over 8 cycles
    sequence s_calc;
        !calc_done [*8] ##[1:400] calc_done;
    endsequence

    a_ready_follows: assert property (s_wait |=> pready)
        else $error("pready missing after access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (pready && paddr > 8'h30 |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped address");
    a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h0)
        else $error("control word not read as zero");
    a_calc_span: assert property (start_acc && calc_done |=> s_calc)
        else $error("done not cleared or late");
    a_done_hold: assert property (calc_done && !start_acc |=> calc_done)
        else $error("done dropped without start");
endmodule

// >>> tb/cfg_agent.sv
// apb configuration agent standing in for the software side
`timescale 1ns/10ps
module cfg_agent (
    // clock
    input wire logic        mclk,
    // apb master
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // only geometry and phases are configured, no gradation mode exists
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale data must not look like a valid word
        pwdata <= ~d;
    endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the partial resize area calculator
`timescale 1ns/10ps
`include "resize_params.svh"
module tb;
    logic        mclk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        calc_done;
    logic [31:0] rd;
    logic        err;
    int          error_cnt;
    int          compares;
    int          seed;

    partial_resize_area_calc #(.DIM_W(16)) DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .calc_done(calc_done));
    cfg_agent agent (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 mclk = ~mclk;

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        agent.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        agent.xfer(1'b0, a, 32'h0, rd, err);
        chk_word(rd, exp);
    endtask

    function automatic int rnd(input int n);
        return int'($unsigned($random(seed)) % n);
    endfunction

    // one axis: dst offset, src offset, dst size, src size, source phase
    function automatic void axis(input longint s, d, lo, hi, fr,
                                 output longint dofs, sofs, dw, sw, ph);
        longint step, q, k;
        step = s * 4096 / d;
        dofs = 0;
        if (lo > 1) begin
            q = d * (lo - 1) / s;
            dofs = (q * step + fr >= (lo - 1) * 4096) ? q : q + 1;
        end
        ph = dofs * step + fr;
        sofs = (lo > 1) ? ph / 4096 : 0;
        if (hi + 2 >= s) begin
            dw = d - dofs;
            sw = s - sofs;
        end else begin
            q = d * (hi + 1) / s;
            k = (q * step + fr >= (hi + 1) * 4096) ? 1 : 0;
            dw = q - dofs + 1 - k;
            sw = ((q - k) * step + fr) / 4096 - sofs + 2;
        end
    endfunction

    task automatic run_case(input int srcw, srch, dstw, dsth, ul, ut, ur, ub, hf, vf,
                            input bit poke);
        longint h[5];
        longint v[5];
        int     n;
        axis(srcw, dstw, ul, ur, hf, h[0], h[1], h[2], h[3], h[4]);
        axis(srch, dsth, ut, ub, vf, v[0], v[1], v[2], v[3], v[4]);
        wr(`RSZ_OFS_SRC_SIZE, {16'(srch), 16'(srcw)});
        wr(`RSZ_OFS_DST_SIZE, {16'(dsth), 16'(dstw)});
        wr(`RSZ_OFS_UPD_LT, {16'(ut), 16'(ul)});
        wr(`RSZ_OFS_UPD_RB, {16'(ub), 16'(ur)});
        wr(`RSZ_OFS_PHASE_FRAC, {4'h0, 12'(vf), 4'h0, 12'(hf)});
        wr(`RSZ_OFS_CTRL, 32'h1);
        // busy at once, done cleared by the accepted start
        rdchk(`RSZ_OFS_STATUS, 32'h0000_0001);
        if (poke) begin
            // both must be ignored while the axes are busy
            wr(`RSZ_OFS_SRC_SIZE, 32'h0003_0003);
            wr(`RSZ_OFS_CTRL, 32'h1);
        end
        n = 0;
        do begin
            agent.xfer(1'b0, `RSZ_OFS_STATUS, 32'h0, rd, err);
            n++;
        end while (rd[1] !== 1'b1 && n < 300);
        chk_word(rd, 32'h0000_0002);
        chk_word({31'h0, calc_done}, 32'h0000_0001);
        rdchk(`RSZ_OFS_SRC_SIZE, {16'(srch), 16'(srcw)});
        rdchk(`RSZ_OFS_RES_DST_LT, {16'(v[0]), 16'(h[0])});
        rdchk(`RSZ_OFS_RES_SRC_LT, {16'(v[1]), 16'(h[1])});
        rdchk(`RSZ_OFS_RES_DST_WH, {16'(v[2]), 16'(h[2])});
        rdchk(`RSZ_OFS_RES_SRC_WH, {16'(v[3]), 16'(h[3])});
        rdchk(`RSZ_OFS_RES_H_PH, 32'(h[4] & 'h3fffff));
        rdchk(`RSZ_OFS_RES_V_PH, 32'(v[4] & 'h1fffff));
    endtask

    task automatic rnd_case(input bit poke);
        int s[2];
        int d[2];
        int lo[2];
        int hi[2];
        int f[2];
        for (int j = 0; j < 2; j++) begin
            s[j] = 16 + rnd(465);
            d[j] = 16 + rnd(465);
            lo[j] = rnd(s[j]);
            hi[j] = lo[j] + rnd(s[j] - lo[j]);
            f[j] = (d[j] > s[j]) ? rnd(s[j] * 4096 / d[j]) : rnd(4096);
        end
        run_case(s[0], s[1], d[0], d[1], lo[0], lo[1], hi[0], hi[1], f[0], f[1], poke);
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        error_cnt = 0;
        compares = 0;
        seed = 20991;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 'h30; a += 4) begin
            rdchk(8'(a), 32'h0);
        end
        run_case(280, 100, 350, 50, 55, 1, 133, 98, 'h333, 'h800, 1'b0);
        rdchk(`RSZ_OFS_RES_H_PH, 32'h0003_6963);
        rdchk(`RSZ_OFS_RES_SRC_WH, 32'h0064_0051);
        // result registers are read-only
        wr(`RSZ_OFS_RES_DST_LT, 32'hffff_ffff);
        rdchk(`RSZ_OFS_RES_DST_LT, 32'h0000_0044);
        agent.xfer(1'b1, 8'hfc, 32'h1, rd, err);
        chk_word({31'h0, err}, 32'h1);
        agent.xfer(1'b0, 8'h40, 32'h0, rd, err);
        chk_word({31'h0, err}, 32'h1);
        // offsets just above one, right and bottom just inside and at the edge
        run_case(64, 64, 48, 100, 2, 0, 61, 62, 'hfff, 'ha3c, 1'b1);
        run_case(40, 90, 120, 30, 1, 2, 38, 87, 'h000, 'hfff, 1'b0);
        for (int i = 0; i < 20; i++) begin
            rnd_case(i % 4 == 0);
        end
        // reset after the last run has finished clears results and status
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk(`RSZ_OFS_RES_DST_WH, 32'h0);
        rdchk(`RSZ_OFS_STATUS, 32'h0);
        chk_word({31'h0, calc_done}, 32'h0);
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
endmodule

bind partial_resize_area_calc resize_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .calc_done(calc_done));
